// File: hw/ctm_map.svh
// How it works
// [RULE_01] 16-bit up-counter counts selected edges when on, unpaused
// [RULE_02] Comparator P checks period against counter bits 15:8
// [RULE_03] Comparator A checks all sixteen counter bits
// [RULE_04] Counter not writable; software clears it only by switching on
// [RULE_05] Overflow or selected match clears counter, raises request
// [RULE_06] Pause holds count; release resumes from held value
// [RULE_07] Three-bit field selects one of eight count sources
// [RULE_08] Switching off stops counting, keeps residual value
// [RULE_09] Switching on clears counter to zero first
// [RULE_10] Switching on restores initial output level, compare mode
// [RULE_11] Low byte write only loads holding buffer
// [RULE_12] High byte write also copies buffer to low
// [RULE_13] High byte read captures live low byte into buffer
// [RULE_14] Low byte read returns holding buffer contents
// [RULE_15] Software writes low first, reads high first
// [RULE_16] Counter pair read-only, match pair and period read/write
// [RULE_17] Pin enable bits 0 to 2 connect outputs
// [RULE_18] Pin enable bit 7 enables tick output pin
// [RULE_19] Unimplemented control bits read as zero
// [RULE_20] Two-bit mode: compare, undefined, PWM, plain timer
// [RULE_21] Output function on A match: keep, low, high, toggle
// [RULE_22] Clear select: 0 period match, 1 A match
// [RULE_23] Output control: initial level, or PWM active level
// [RULE_24] External input synchronised, selected edge gives one pulse
// [RULE_25] Separate A and P match flags set on match
`ifndef CTM_MAP_SVH
`define CTM_MAP_SVH
// Register byte offsets
`define CTM_OFS_PIN_EN    8'h00
`define CTM_OFS_CLK_RUN   8'h04
`define CTM_OFS_MODE      8'h08
`define CTM_OFS_CNT_LO    8'h0C
`define CTM_OFS_CNT_HI    8'h10
`define CTM_OFS_MA_LO     8'h14
`define CTM_OFS_MA_HI     8'h18
`define CTM_OFS_PERIOD    8'h1C
`define CTM_OFS_FLAGS     8'h20
// Field positions
`define CTM_RUN_PAUSE     7
`define CTM_RUN_SRC_HI    6
`define CTM_RUN_SRC_LO    4
`define CTM_RUN_ON        3
`define CTM_MODE_HI       7
`define CTM_MODE_LO       6
`define CTM_FUNC_HI       5
`define CTM_FUNC_LO       4
`define CTM_MODE_OC       3
`define CTM_MODE_POL      2
`define CTM_MODE_DPX      1
`define CTM_MODE_CCLR     0
`define CTM_PIN_TICK      7
// Implemented bit masks
`define CTM_PIN_MASK      8'h87
`define CTM_RUN_MASK      8'hF8
// Reset values
`define CTM_RST_BYTE      8'h00
`define CTM_RST_WORD      16'h0000
// Prescaler terminal counts
`define CTM_DIV4_LAST     6'h03
`define CTM_DIV16_LAST    6'h0F
`define CTM_DIV64_LAST    6'h3F
`endif

// File: hw/ctm_pkg.sv
package ctm_pkg;
   // APB request from the master
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
   } ctm_apb_req_t;
   // APB answer to the master
   typedef struct packed {
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } ctm_apb_rsp_t;
   // Bus phase
   typedef enum logic [1:0] {
      CTM_PH_IDLE = 2'b01,
      CTM_PH_ACC  = 2'b10
   } ctm_phase_t;
   // Operating modes
   typedef enum logic [1:0] {
      CTM_MD_CMP   = 2'b00,
      CTM_MD_UNDEF = 2'b01,
      CTM_MD_PWM   = 2'b10,
      CTM_MD_TIMER = 2'b11
   } ctm_mode_t;
   // Count sources
   typedef enum logic [2:0] {
      CTM_SRC_SYS4  = 3'b000,
      CTM_SRC_SYS   = 3'b001,
      CTM_SRC_HI16  = 3'b010,
      CTM_SRC_HI64  = 3'b011,
      CTM_SRC_TBC   = 3'b100,
      CTM_SRC_HI    = 3'b101,
      CTM_SRC_RISE  = 3'b110,
      CTM_SRC_FALL  = 3'b111
   } ctm_src_t;
endpackage : ctm_pkg

// File: hw/ctm_top.sv
// Our own choices: the APB slave port and the register offsets.
`timescale 1ns/1ps
`include "ctm_map.svh"
module ctm_top #(
   parameter int PIN_IDX = 2
) (
   input  wire logic                  ref_clk_i,
   input  wire logic                  srst_i,
   input  wire ctm_pkg::ctm_apb_req_t apb_req_i,
   output ctm_pkg::ctm_apb_rsp_t      apb_rsp_o,
   input  wire logic                  hi_tick_i,
   input  wire logic                  tbc_tick_i,
   input  wire logic                  external_count_i,
   output logic                       timer_output_pin_o,
   output logic                       timer_output_pin_oe_o,
   output logic [2:0]                 output_pin_enable_o,
   output logic                       tick_output_pin_enable_o,
   output logic                       match_a_flag_o,
   output logic                       match_p_flag_o
);

   logic [7:0]          pin_en_reg;
   logic [7:0]          run_reg;
   logic [7:0]          mode_reg;
   logic [15:0]         cnt_reg;
   logic [15:0]         cnt_next;
   logic [15:0]         ma_reg;
   logic [7:0]          period_reg;
   logic [7:0]          hold_reg;
   logic [1:0]          flag_reg;
   logic                on_dly_reg;
   logic [5:0]          sys_div_reg;
   logic [5:0]          hi_div_reg;
   logic [2:0]          ext_sync_reg;
   logic                tick;
   logic                sys4_tick;
   logic                hi16_tick;
   logic                hi64_tick;
   logic                ext_rise;
   logic                ext_fall;
   logic                on_rise;
   logic                running;
   logic                step;
   logic [15:0]         inc;
   logic                hit_a;
   logic                hit_p;
   logic                clr;
   logic                out_reg;
   logic                pwm_act;
   logic                pin_oe_next;
   logic                pin_next;
   ctm_pkg::ctm_phase_t phase_reg;
   ctm_pkg::ctm_apb_rsp_t rsp_reg;
   logic [31:0]         rdata_next;
   logic                bad_next;
   logic                setup;
   logic                done;
   logic                wr;
   logic                cap_cnt;
   logic                cap_ma;
   logic [7:0]          wbyte;
   logic [7:0]          adr;
   ctm_pkg::ctm_mode_t  mode;
   ctm_pkg::ctm_src_t   src;

   // Field decode
   assign mode  = ctm_pkg::ctm_mode_t'(
                     mode_reg[`CTM_MODE_HI:`CTM_MODE_LO]);
   assign src   = ctm_pkg::ctm_src_t'(
                     run_reg[`CTM_RUN_SRC_HI:`CTM_RUN_SRC_LO]);
   assign adr   = apb_req_i.paddr;
   assign wbyte = apb_req_i.pwdata[7:0];

   // Bus handshake terms
   assign setup = apb_req_i.psel && !apb_req_i.penable;
   assign done  = apb_req_i.psel && apb_req_i.penable && rsp_reg.pready &&
                  phase_reg == ctm_pkg::CTM_PH_ACC;
   assign wr    = done && apb_req_i.pwrite;

   // High byte reads are caught in the setup cycle, the same edge at which
   // the high byte is latched, so the pair cannot tear across a carry
   assign cap_cnt = setup && !apb_req_i.pwrite &&
                    adr == `CTM_OFS_CNT_HI; // RULE_13
   assign cap_ma  = setup && !apb_req_i.pwrite &&
                    adr == `CTM_OFS_MA_HI; // RULE_13

   // Bus phase tracker: answer in the first access cycle
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         phase_reg <= ctm_pkg::CTM_PH_IDLE;
      end else begin
         case (phase_reg)
            ctm_pkg::CTM_PH_IDLE: begin
               if (setup) begin
                  phase_reg <= ctm_pkg::CTM_PH_ACC;
               end
            end
            ctm_pkg::CTM_PH_ACC: begin
               phase_reg <= setup ? ctm_pkg::CTM_PH_ACC
                                  : ctm_pkg::CTM_PH_IDLE;
            end
            default: begin
               phase_reg <= ctm_pkg::CTM_PH_IDLE;
            end
         endcase
      end
   end

   // Read mux, sampled in the setup cycle; unmapped offsets read as zero
   // and answer with an error
   always_comb begin
      rdata_next = 32'h0000_0000;
      bad_next   = 1'b0;
      case (adr)
         `CTM_OFS_PIN_EN:  rdata_next[7:0] = pin_en_reg & `CTM_PIN_MASK; // RULE_19
         `CTM_OFS_CLK_RUN: rdata_next[7:0] = run_reg & `CTM_RUN_MASK;    // RULE_19
         `CTM_OFS_MODE:    rdata_next[7:0] = mode_reg;
         `CTM_OFS_CNT_LO:  rdata_next[7:0] = hold_reg;     // RULE_14
         `CTM_OFS_CNT_HI:  rdata_next[7:0] = cnt_reg[15:8]; // RULE_13
         `CTM_OFS_MA_LO:   rdata_next[7:0] = hold_reg;     // RULE_14
         `CTM_OFS_MA_HI:   rdata_next[7:0] = ma_reg[15:8];  // RULE_13
         `CTM_OFS_PERIOD:  rdata_next[7:0] = period_reg;   // RULE_16
         `CTM_OFS_FLAGS:   rdata_next[1:0] = flag_reg;
         default:          bad_next = 1'b1;
      endcase
   end

   // Registered answer: ready one cycle after setup
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         rsp_reg <= '0;
      end else begin
         rsp_reg.pready <= setup;
         if (setup) begin
            rsp_reg.prdata  <= apb_req_i.pwrite ? 32'h0000_0000
                                                : rdata_next;
            rsp_reg.pslverr <= bad_next;
         end else if (done) begin
            rsp_reg.pslverr <= 1'b0;
         end
      end
   end

   // Control registers
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         pin_en_reg <= `CTM_RST_BYTE;
         run_reg    <= `CTM_RST_BYTE;
         mode_reg   <= `CTM_RST_BYTE;
         period_reg <= `CTM_RST_BYTE;
      end else if (wr) begin
         case (adr)
            `CTM_OFS_PIN_EN:  pin_en_reg <= wbyte & `CTM_PIN_MASK; // RULE_17
            `CTM_OFS_CLK_RUN: run_reg    <= wbyte & `CTM_RUN_MASK;
            `CTM_OFS_MODE:    mode_reg   <= wbyte;
            `CTM_OFS_PERIOD:  period_reg <= wbyte; // RULE_16
            `CTM_OFS_CNT_LO, `CTM_OFS_CNT_HI: begin // RULE_04
               // Counter bytes are read-only; writes fall away
            end
            default: begin
            end
         endcase
      end
   end

   // Holding buffer for the byte pairs
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         hold_reg <= `CTM_RST_BYTE;
      end else if (wr && adr == `CTM_OFS_MA_LO) begin
         hold_reg <= wbyte; // RULE_11
      end else if (cap_cnt) begin
         hold_reg <= cnt_reg[7:0]; // RULE_13
      end else if (cap_ma) begin
         hold_reg <= ma_reg[7:0]; // RULE_13
      end
   end

   // Match A value: loaded whole on high byte write
   // The low half comes from the holding buffer, so write order matters
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         ma_reg <= `CTM_RST_WORD;
      end else if (wr && adr == `CTM_OFS_MA_HI) begin
         ma_reg <= {wbyte, hold_reg}; // RULE_12
      end
   end

   // Prescaler on the system clock
   // Free running: a source switch never restarts the divider
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         sys_div_reg <= 6'h00;
      end else begin
         sys_div_reg <= sys4_tick ? 6'h00 : sys_div_reg + 6'h01;
      end
   end
   assign sys4_tick = (sys_div_reg == `CTM_DIV4_LAST);

   // Prescaler on the high speed tick
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         hi_div_reg <= 6'h00;
      end else if (hi_tick_i) begin
         hi_div_reg <= hi_div_reg + 6'h01;
      end
   end
   assign hi16_tick = hi_tick_i &&
                      ({2'b00, hi_div_reg[3:0]} == `CTM_DIV16_LAST);
   assign hi64_tick = hi_tick_i && (hi_div_reg == `CTM_DIV64_LAST);

   // External input synchroniser and edge detector
   // Two flops settle the pin, the third holds the level to find edges
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         ext_sync_reg <= 3'b000;
      end else begin
         ext_sync_reg <= {ext_sync_reg[1:0], external_count_i}; // RULE_24
      end
   end
   assign ext_rise = ext_sync_reg[1] && !ext_sync_reg[2]; // RULE_24
   assign ext_fall = !ext_sync_reg[1] && ext_sync_reg[2]; // RULE_24

   // Count source select
   always_comb begin
      case (src) // RULE_07
         ctm_pkg::CTM_SRC_SYS4: tick = sys4_tick;
         ctm_pkg::CTM_SRC_SYS:  tick = 1'b1;
         ctm_pkg::CTM_SRC_HI16: tick = hi16_tick;
         ctm_pkg::CTM_SRC_HI64: tick = hi64_tick;
         ctm_pkg::CTM_SRC_TBC:  tick = tbc_tick_i;
         ctm_pkg::CTM_SRC_HI:   tick = hi_tick_i;
         ctm_pkg::CTM_SRC_RISE: tick = ext_rise;
         ctm_pkg::CTM_SRC_FALL: tick = ext_fall;
         default:               tick = 1'b0;
      endcase
   end

   // Run state and switch-on edge
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         on_dly_reg <= 1'b0;
      end else begin
         on_dly_reg <= run_reg[`CTM_RUN_ON];
      end
   end
   assign on_rise = run_reg[`CTM_RUN_ON] && !on_dly_reg;
   assign running = run_reg[`CTM_RUN_ON] &&
                    !run_reg[`CTM_RUN_PAUSE]; // RULE_06 RULE_08
   assign step    = running && tick && !on_rise; // RULE_01

   // Comparators look at the value the counter is about to take
   assign inc   = cnt_reg + 16'h0001;
   assign hit_a = step && (inc == ma_reg); // RULE_03
   assign hit_p = step && (inc[15:8] == period_reg) &&
                  (inc[7:0] == 8'h00); // RULE_02
   assign clr   = mode_reg[`CTM_MODE_CCLR] ? hit_a : hit_p; // RULE_22

   // Counter: no software write path
   // A switch-on edge wins over a tick that falls in the same cycle
   always_comb begin
      cnt_next = cnt_reg; // RULE_06 RULE_08
      if (on_rise) begin
         cnt_next = `CTM_RST_WORD; // RULE_09 RULE_04
      end else if (step) begin
         cnt_next = clr ? `CTM_RST_WORD : inc; // RULE_05 RULE_01
      end
   end
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         cnt_reg <= `CTM_RST_WORD;
      end else begin
         cnt_reg <= cnt_next;
      end
   end

   // Match flags: set wins over a write-one clear
   generate
      for (genvar i = 0; i < 2; i++) begin : g_flag
         logic hit;
         assign hit = (i == 0) ? hit_a : hit_p;
         always_ff @(posedge ref_clk_i) begin
            if (srst_i) begin
               flag_reg[i] <= 1'b0;
            end else if (hit) begin
               flag_reg[i] <= 1'b1; // RULE_25 RULE_05
            end else if (wr && adr == `CTM_OFS_FLAGS &&
                         wbyte[i]) begin
               flag_reg[i] <= 1'b0;
            end
         end
      end
   endgenerate

   // Compare output level
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         out_reg <= 1'b0;
      end else if (mode == ctm_pkg::CTM_MD_CMP) begin
         if (on_rise) begin
            out_reg <= mode_reg[`CTM_MODE_OC]; // RULE_10 RULE_23
         end else if (hit_a) begin
            case (mode_reg[`CTM_FUNC_HI:`CTM_FUNC_LO]) // RULE_21
               2'b01:   out_reg <= 1'b0;
               2'b10:   out_reg <= 1'b1;
               2'b11:   out_reg <= !out_reg;
               default: out_reg <= out_reg;
            endcase
         end
      end
   end

   // PWM active phase: duty from A or period, chosen by swap bit
   // Function and mode bits should only change while switched off
   always_comb begin
      case (mode_reg[`CTM_FUNC_HI:`CTM_FUNC_LO])
         2'b00:   pwm_act = 1'b0;
         2'b01:   pwm_act = 1'b1;
         2'b10:   pwm_act = mode_reg[`CTM_MODE_DPX] ?
                            (cnt_reg[15:8] < period_reg) :
                            (cnt_reg < ma_reg);
         default: pwm_act = 1'b0;
      endcase
   end

   // Pin level and enable ahead of the output flops
   always_comb begin
      pin_next    = out_reg;
      pin_oe_next = pin_en_reg[PIN_IDX]; // RULE_17
      case (mode) // RULE_20
         ctm_pkg::CTM_MD_CMP: begin
            pin_next = out_reg;
         end
         ctm_pkg::CTM_MD_PWM: begin
            pin_next = mode_reg[`CTM_MODE_OC] ? pwm_act
                                              : !pwm_act; // RULE_23
            pin_oe_next = pin_oe_next && run_reg[`CTM_RUN_ON];
         end
         ctm_pkg::CTM_MD_TIMER: begin
            pin_oe_next = 1'b0;
         end
         default: begin
            pin_next = out_reg;
         end
      endcase
      if (mode != ctm_pkg::CTM_MD_TIMER) begin
         pin_next = pin_next ^ mode_reg[`CTM_MODE_POL];
      end
   end

   // Registered outputs
   // Flags reach the pins one cycle after they are set
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         timer_output_pin_o       <= 1'b0;
         timer_output_pin_oe_o    <= 1'b0;
         output_pin_enable_o      <= 3'b000;
         tick_output_pin_enable_o <= 1'b0;
         match_a_flag_o           <= 1'b0;
         match_p_flag_o           <= 1'b0;
      end else begin
         timer_output_pin_o       <= pin_next;
         timer_output_pin_oe_o    <= pin_oe_next;
         output_pin_enable_o      <= pin_en_reg[2:0]; // RULE_17
         tick_output_pin_enable_o <= pin_en_reg[`CTM_PIN_TICK]; // RULE_18
         match_a_flag_o           <= flag_reg[0];
         match_p_flag_o           <= flag_reg[1];
      end
   end

   assign apb_rsp_o = rsp_reg;

endmodule : ctm_top

// File: verification/ctm_pins_model.sv
`timescale 1ns/1ps
module ctm_pins_model (
   input  wire logic ref_clk_i,
   output logic      hi_tick_o,
   output logic      tbc_tick_o,
   output logic      ext_o
);
   logic [2:0] div_q = 3'h0;
   // Count pin rests low until pulses are asked for
   initial ext_o = 1'b0;
   // Tick enables: high tick every 2 cycles, time base every 8
   always @(posedge ref_clk_i) begin
      div_q <= div_q + 3'h1;
      hi_tick_o <= div_q[0];
      tbc_tick_o <= (div_q == 3'h7);
   end
   // Full pulses on the count pin, high for four cycles, low for at least four
   task automatic pulses(input int n);
      repeat (n) begin
         @(posedge ref_clk_i);
         ext_o <= 1'b1;
         repeat (4) @(posedge ref_clk_i);
         ext_o <= 1'b0;
         repeat (4) @(posedge ref_clk_i);
      end
      #1;
   endtask : pulses
endmodule : ctm_pins_model

// File: verification/ctm_top_checker.sv
`timescale 1ns/1ps
`include "ctm_map.svh"
module ctm_top_checker #(
   parameter int PIN_IDX = 2
) (
   input wire logic                  ref_clk_i,
   input wire logic                  srst_i,
   input wire ctm_pkg::ctm_apb_req_t apb_req_i,
   input wire ctm_pkg::ctm_apb_rsp_t apb_rsp_o,
   input wire logic                  timer_output_pin_o,
   input wire logic                  timer_output_pin_oe_o,
   input wire logic [2:0]            output_pin_enable_o,
   input wire logic                  tick_output_pin_enable_o,
   input wire logic                  match_a_flag_o,
   input wire logic                  match_p_flag_o
);
   logic       wr;
   logic       setup;
   logic       clr_a;
   logic       clr_p;
   logic [7:0] mode_q;
   logic [7:0] run_q;
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (srst_i);
   // Bus phases and flag clear writes
   assign setup = apb_req_i.psel & ~apb_req_i.penable;
   assign wr = apb_req_i.psel & apb_req_i.penable & apb_rsp_o.pready
      & apb_req_i.pwrite;
   assign clr_a = wr && apb_req_i.paddr == `CTM_OFS_FLAGS
      && apb_req_i.pwdata[0];
   assign clr_p = wr && apb_req_i.paddr == `CTM_OFS_FLAGS
      && apb_req_i.pwdata[1];
   // Shadow of mode and run registers
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         mode_q <= 8'h00;
         run_q <= 8'h00;
      end else if (wr && apb_req_i.paddr == `CTM_OFS_MODE) begin
         mode_q <= apb_req_i.pwdata[7:0];
      end else if (wr && apb_req_i.paddr == `CTM_OFS_CLK_RUN) begin
         run_q <= apb_req_i.pwdata[7:0];
      end
   end
   a_ready_next: assert property (setup |=> apb_rsp_o.pready)
      else $error("no answer");
   a_bad_addr_err: assert property (
      setup && apb_req_i.paddr > `CTM_OFS_FLAGS |=> apb_rsp_o.pslverr)
      else $error("no error on bad address");
   a_pin_en_copy: assert property (
      wr && apb_req_i.paddr == `CTM_OFS_PIN_EN |=> ##1
      {tick_output_pin_enable_o, output_pin_enable_o} ==
      {$past(apb_req_i.pwdata[7], 2), $past(apb_req_i.pwdata[2:0], 2)})
      else $error("pin enables wrong");
   a_rd_zero_bits: assert property (
      apb_rsp_o.pready && !apb_req_i.pwrite |->
      apb_rsp_o.prdata[31:8] == 24'h00_0000 &&
      (apb_req_i.paddr != 8'h00 || apb_rsp_o.prdata[6:3] == 4'h0) &&
      (apb_req_i.paddr != 8'h04 || apb_rsp_o.prdata[2:0] == 3'h0))
      else $error("unused bits not zero");
   a_timer_no_oe: assert property (
      mode_q[7:6] == 2'h3 && $past(mode_q[7:6]) == 2'h3 &&
      $past(mode_q[7:6], 2) == 2'h3 |-> !timer_output_pin_oe_o)
      else $error("pin driven in timer mode");
   a_flag_a_clear: assert property (
      $fell(match_a_flag_o) |-> $past(clr_a, 2))
      else $error("flag A lost");
   a_flag_p_clear: assert property (
      $fell(match_p_flag_o) |-> $past(clr_p, 2))
      else $error("flag P lost");
   a_on_init_level: assert property (
      wr && apb_req_i.paddr == `CTM_OFS_CLK_RUN && apb_req_i.pwdata[3] &&
      !run_q[3] && mode_q[7:6] == 2'h0 |->
      ##[1:3] timer_output_pin_o == (mode_q[3] ^ mode_q[2]))
      else $error("pin not at initial level");
   c_write: cover property (wr);
   c_match_a: cover property ($rose(match_a_flag_o));
   c_match_p: cover property ($rose(match_p_flag_o));
endmodule : ctm_top_checker
bind ctm_top ctm_top_checker #(.PIN_IDX(PIN_IDX)) u_ctm_chk (
   .ref_clk_i(ref_clk_i), .srst_i(srst_i), .apb_req_i(apb_req_i),
   .apb_rsp_o(apb_rsp_o), .timer_output_pin_o(timer_output_pin_o),
   .timer_output_pin_oe_o(timer_output_pin_oe_o),
   .output_pin_enable_o(output_pin_enable_o),
   .tick_output_pin_enable_o(tick_output_pin_enable_o),
   .match_a_flag_o(match_a_flag_o), .match_p_flag_o(match_p_flag_o)
);

// File: verification/test_compact_timer_module.sv
`timescale 1ns/1ps
`include "ctm_map.svh"
module test_compact_timer_module;
   localparam logic [7:0] RUN = `CTM_OFS_CLK_RUN;
   localparam logic [7:0] MOD = `CTM_OFS_MODE;
   localparam logic [7:0] FLG = `CTM_OFS_FLAGS;
   localparam logic [7:0] CHI = `CTM_OFS_CNT_HI;
   localparam logic [7:0] CLO = `CTM_OFS_CNT_LO;
   localparam logic [7:0] AHI = `CTM_OFS_MA_HI;
   localparam logic [7:0] ALO = `CTM_OFS_MA_LO;
   localparam logic [7:0] PER = `CTM_OFS_PERIOD;
   logic                  ref_clk_i;
   logic                  srst_i = 1'b1;
   ctm_pkg::ctm_apb_req_t req = '0;
   ctm_pkg::ctm_apb_rsp_t rsp;
   logic                  hi_tick;
   logic                  tbc_tick;
   logic                  ext_pin;
   logic                  pin;
   logic                  pin_oe;
   logic [2:0]            pin_en;
   logic                  tick_en;
   logic                  flag_a;
   logic                  flag_p;
   logic [31:0]           rdat;
   logic                  rerr;
   logic [15:0]           v16;
   int                    err_total = 0;
   int                    num_checks = 0;
   int                    cyc = 0;
   ctm_top i_ctm_top (
      .ref_clk_i(ref_clk_i), .srst_i(srst_i), .apb_req_i(req),
      .apb_rsp_o(rsp), .hi_tick_i(hi_tick), .tbc_tick_i(tbc_tick),
      .external_count_i(ext_pin), .timer_output_pin_o(pin),
      .timer_output_pin_oe_o(pin_oe), .output_pin_enable_o(pin_en),
      .tick_output_pin_enable_o(tick_en), .match_a_flag_o(flag_a),
      .match_p_flag_o(flag_p));
   ctm_pins_model i_ctm_pins_model (.ref_clk_i(ref_clk_i),
      .hi_tick_o(hi_tick), .tbc_tick_o(tbc_tick), .ext_o(ext_pin));
   // Clock and cycle count
   initial begin
      ref_clk_i = 1'b0;
      forever #12.5 ref_clk_i = ~ref_clk_i;
   end
   always @(posedge ref_clk_i) cyc <= cyc + 1;
   task automatic end_of_test();
      if (err_total == 0 && num_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : end_of_test
   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
      end
   endtask : chk_val
   task automatic chk_bit(input logic got, input logic exp);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED %0t bit %b want %b", $time, got, exp);
      end
   endtask : chk_bit
   task automatic step(input int n);
      repeat (n) @(posedge ref_clk_i);
      #1;
   endtask : step
   // One APB transfer, held until pready is seen
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge ref_clk_i);
      req <= '{psel:1'b1, penable:1'b0, pwrite:w, paddr:a, pwdata:d};
      @(posedge ref_clk_i);
      req.penable <= 1'b1;
      @(posedge ref_clk_i);
      while (rsp.pready !== 1'b1 && n < 20) begin
         @(posedge ref_clk_i);
         n++;
      end
      if (n >= 20) begin
         err_total++;
      end
      rdat = rsp.prdata;
      rerr = rsp.pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
      #1;
   endtask : bus
   // High byte first, then buffered low byte
   task automatic rd16(input logic [7:0] hi, input logic [7:0] lo,
                       input int exp, input int tol);
      bus(1'b0, hi, 8'h00);
      v16[15:8] = rdat[7:0];
      bus(1'b0, lo, 8'h00);
      v16[7:0] = rdat[7:0];
      chk_bit(v16 + tol >= exp && v16 <= exp + tol, 1'b1);
   endtask : rd16
   task automatic t_regs();
      for (int a = 0; a <= 36; a += 4) begin
         bus(1'b0, a[7:0], 8'h00);
         chk_val(rdat, 32'h0000_0000);
         chk_bit(rerr, a == 36);
      end
      bus(1'b1, 8'h00, 32'hA5A5_A5FF);
      bus(1'b0, 8'h00, 8'h00);
      chk_val(rdat, 32'h0000_0087);
      chk_val({28'h000_0000, tick_en, pin_en}, 32'h0000_000F);
      bus(1'b1, RUN, 8'h07);
      bus(1'b0, RUN, 8'h00);
      chk_val(rdat, 32'h0000_0000);
      bus(1'b1, 8'h00, 8'h04);
   endtask : t_regs
   task automatic t_buffer();
      bus(1'b1, ALO, 8'h34);
      rd16(AHI, ALO, 0, 0);
      bus(1'b1, AHI, 8'h12);
      rd16(AHI, ALO, 16'h1200, 0);
      bus(1'b1, ALO, 8'h34);
      bus(1'b1, AHI, 8'h12);
      rd16(AHI, ALO, 16'h1234, 0);
      bus(1'b1, PER, 8'h5A);
      bus(1'b0, PER, 8'h00);
      chk_val(rdat, 32'h0000_005A);
   endtask : t_buffer
   task automatic t_count();
      bus(1'b1, MOD, 8'hC0);
      bus(1'b1, RUN, 8'h68);
      i_ctm_pins_model.pulses(5);
      rd16(CHI, CLO, 5, 0);
      bus(1'b1, RUN, 8'h78);
      i_ctm_pins_model.pulses(3);
      rd16(CHI, CLO, 8, 0);
      bus(1'b1, RUN, 8'hF8);
      i_ctm_pins_model.pulses(2);
      rd16(CHI, CLO, 8, 0);
      bus(1'b1, RUN, 8'h78);
      i_ctm_pins_model.pulses(2);
      rd16(CHI, CLO, 10, 0);
      bus(1'b1, RUN, 8'h70);
      i_ctm_pins_model.pulses(2);
      rd16(CHI, CLO, 10, 0);
      bus(1'b1, CHI, 8'hFF);
      bus(1'b1, CLO, 8'hFF);
      rd16(CHI, CLO, 10, 0);
      bus(1'b1, RUN, 8'h78);
      rd16(CHI, CLO, 0, 0);
   endtask : t_count
   task automatic t_match_a();
      bus(1'b1, ALO, 8'h03);
      bus(1'b1, AHI, 8'h00);
      for (int f = 0; f < 4; f++) begin
         bus(1'b1, RUN, 8'h00);
         bus(1'b1, MOD, {2'h0, f[1:0], 4'h9});
         bus(1'b1, RUN, 8'h68);
         step(2);
         chk_bit(pin, 1'b1);
         chk_bit(pin_oe, 1'b1);
         i_ctm_pins_model.pulses(3);
         chk_bit(flag_a, 1'b1);
         chk_bit(pin, !f[0]);
         rd16(CHI, CLO, 0, 0);
         bus(1'b1, FLG, 8'h01);
         step(2);
         chk_bit(flag_a, 1'b0);
      end
   endtask : t_match_a
   task automatic t_src();
      int div [6] = '{4, 1, 32, 128, 8, 2};
      int t0;
      bus(1'b1, PER, 8'hFF);
      for (int s = 0; s < 6; s++) begin
         bus(1'b1, RUN, 8'h00);
         bus(1'b1, MOD, {s[1:0], 6'h00});
         bus(1'b1, RUN, {1'b0, s[2:0], 4'h8});
         t0 = cyc;
         step(260);
         chk_bit(pin_oe, s != 3);
         if (s == 2) begin
            chk_bit(pin, 1'b1);
         end
         rd16(CHI, CLO, (cyc - t0 + 2) / div[s], 3);
      end
   endtask : t_src
   task automatic t_match_p();
      int n;
      n = 0;
      bus(1'b1, RUN, 8'h00);
      bus(1'b1, MOD, 8'hC0);
      bus(1'b1, PER, 8'h01);
      bus(1'b1, RUN, 8'h18);
      while (flag_p !== 1'b1 && n < 400) begin
         step(1);
         n++;
      end
      chk_bit(n >= 250 && n <= 262, 1'b1);
      rd16(CHI, CLO, 8, 8);
      bus(1'b1, FLG, 8'h02);
      step(2);
      chk_bit(flag_p, 1'b0);
   endtask : t_match_p
   // Watchdog against a hung handshake
   initial begin
      repeat (20000) @(posedge ref_clk_i);
      err_total++;
      end_of_test();
   end
   // Reset, then the scenarios in order
   initial begin
      repeat (5) @(posedge ref_clk_i);
      srst_i <= 1'b0;
      t_regs();
      t_buffer();
      t_count();
      t_match_a();
      t_src();
      t_match_p();
      end_of_test();
   end
endmodule : test_compact_timer_module
